// ==== resq_pkg.sv ====
// Package for the regulator enable sequencer: register map, field positions,
// reset values and timing counts.
// Assumes a 100 MHz core clock.
package resq_pkg;
    // Register offsets (byte register address on the serial register port)
    localparam logic [7:0] RESQ_OFS_LIN0_CTRL = 8'h08;
    localparam logic [7:0] RESQ_OFS_LIN1_CTRL = 8'h09;
    localparam logic [7:0] RESQ_OFS_LIN0_LVL = 8'h0A;
    localparam logic [7:0] RESQ_OFS_LIN1_LVL = 8'h0B;
    localparam logic [7:0] RESQ_OFS_CONV0_DLY = 8'h0C;
    localparam logic [7:0] RESQ_OFS_CONV1_DLY = 8'h0D;
    localparam logic [7:0] RESQ_OFS_LIN0_DLY = 8'h0E;
    localparam logic [7:0] RESQ_OFS_DLY_CFG = 8'h13;
    // Control field positions
    localparam int RESQ_BIT_ON = 0;
    localparam int RESQ_BIT_GATE = 1;
    localparam int RESQ_BIT_DIS = 2;
    // Doubling bits in the delay configuration register
    localparam int RESQ_BIT_OFF_X2 = 1;
    localparam int RESQ_BIT_ON_X2 = 0;
    // Reset values
    localparam logic [7:0] RESQ_RST_CTRL = 8'h04;
    localparam logic [7:0] RESQ_RST_ZERO = 8'h00;
    // Writable masks: reserved bits of level register stay zero
    localparam logic [7:0] RESQ_MASK_LVL = 8'h1F;
    localparam logic [7:0] RESQ_MASK_CTRL = 8'h07;
    localparam logic [7:0] RESQ_MASK_CFG = 8'h03;
    // Time base: one delay step is 0.5 ms
    localparam int RESQ_CLK_MHZ = 100;
    localparam int RESQ_STEP_US = 500;
    localparam int RESQ_STEP_CYC = RESQ_STEP_US * RESQ_CLK_MHZ;
    // Channel count: conv0, conv1, lin0
    localparam int RESQ_NCH = 3;
endpackage

// ==== resq_bus_if.sv ====
// Interface carrying one delay channel's settings and results.
// Assumes the sequencer top drives settings and reads results.
`timescale 1ns/10ps
`default_nettype none
interface resq_bus_if;
    logic [3:0] on_wait;
    logic [3:0] off_wait;
    logic on_x2;
    logic off_x2;
    logic delayed_en;
    logic busy;
    modport top (output on_wait, output off_wait, output on_x2,
                 output off_x2, input delayed_en, input busy);
    modport chan (input on_wait, input off_wait, input on_x2,
                  input off_x2, output delayed_en, output busy);
endinterface
`default_nettype wire

// ==== resq_delay_chan.sv ====
// One edge-delay channel: follows the synchronised enable pin after a
// programmed number of time-base ticks.
// Assumes en_pin is already synchronised and tick is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module resq_delay_chan
    import resq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Timing inputs
    input wire logic en_pin,
    input wire logic tick,
    // Settings and result
    resq_bus_if.chan cfg
);
    logic target_r;
    logic out_r;
    logic [4:0] cnt_r;

    // --------------------------------------------------------------
    // Edge tracking and countdown
    // --------------------------------------------------------------
    // A new edge restarts timing even mid-count, so a glitchy pin never
    // leaves a half-served stale delay behind
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            target_r <= 1'b0;
            cnt_r <= 5'h00;
            out_r <= 1'b0;
        end else if (en_pin != target_r) begin
            target_r <= en_pin; // RL13
            if (en_pin) begin
                cnt_r <= cfg.on_x2 ? {cfg.on_wait, 1'b0} // RL9
                                   : {1'b0, cfg.on_wait}; // RL8
            end else begin
                cnt_r <= cfg.off_x2 ? {cfg.off_wait, 1'b0} // RL7
                                    : {1'b0, cfg.off_wait}; // RL6
            end
        end else if (cnt_r == 5'h00) begin
            out_r <= target_r;
        end else if (tick) begin
            cnt_r <= cnt_r - 5'h01; // RL12
        end
    end

    assign cfg.delayed_en = out_r;
    assign cfg.busy = (out_r != target_r);
endmodule
`default_nettype wire

// ==== resq_top.sv ====
// Regulator enable sequencer: control and level registers for two linear regulators,
// delay registers for two step-down converters and linear regulator 0, plus enable-pin timing.
// Assumes a byte register port decoded by a serial front end on REF_CLK.
// Assumes EN_PIN may move at any time relative to REF_CLK.
// Assumes software keeps level codes below 1A; they are not clamped.
// Assumes only this block drives the regulator enable inputs.
// Contract
// RL1: Discharge applied when disabled and bit set
// RL2: Gating bit selects bit-only or bit-and-pin
// RL3: Enable bit zero off, one on
// RL4: Code 0 is 0.8 V, 100 mV steps
// RL5: Software avoids level codes 1A to 1F
// RL6: Converter 0 off wait, upper nibble
// RL7: Off doubling makes each step 1 ms
// RL8: Converter 0 on wait, lower nibble
// RL9: On doubling makes each step 1 ms
// RL10: Converter 1 has own waits, same coding
// RL11: Linear regulator 0 has own wait register
// RL12: Gated enable is bit AND delayed pin; linear regulator 1 uses the synchronised pin undelayed
// RL13: Pin change mid-count restarts timing
`timescale 1ns/10ps
`default_nettype none
module resq_top
    import resq_pkg::*;
#(
    parameter int STEP_CYC = RESQ_STEP_CYC
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Register port
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Enable pin
    input wire logic EN_PIN,
    // Regulator controls
    output logic LIN0_ENABLE,
    output logic LIN1_ENABLE,
    output logic CONV0_START,
    output logic CONV1_START,
    output logic LIN0_DISCHARGE,
    output logic LIN1_DISCHARGE,
    output logic [4:0] LIN0_LEVEL_CODE,
    output logic [4:0] LIN1_LEVEL_CODE,
    output logic SEQ_BUSY
);
    // --------------------------------------------------------------
    // Storage and internal nets
    // --------------------------------------------------------------
    // Register file, one byte per mapped offset
    logic [7:0] lin0_control_r;
    logic [7:0] linear_regulator_1_control_r;
    logic [7:0] linear_regulator_0_level_r;
    logic [7:0] linear_regulator_1_level_r;
    logic [7:0] step_down_converter_0_sequence_delays_r;
    logic [7:0] step_down_converter_1_sequence_delays_r;
    logic [7:0] linear_regulator_0_sequence_delays_r;
    logic [7:0] dly_cfg_r;

    // Pin synchroniser and time base
    logic pin_meta_r;
    logic pin_sync_r;
    logic [31:0] tick_cnt_r;
    logic tick;

    // Delay channel settings and results
    logic [RESQ_NCH-1:0] dly_en;
    logic [RESQ_NCH-1:0] dly_busy;
    logic [7:0] dly_regs [RESQ_NCH];

    // Read path and effective enables
    logic [7:0] rdata_nxt;
    logic lin0_on;
    logic lin1_on;

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    // Reserved bits are masked so they always read back as zero
    // Delay bytes take all eight bits; both nibbles are live
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            lin0_control_r <= RESQ_RST_CTRL;
            linear_regulator_1_control_r <= RESQ_RST_CTRL;
            linear_regulator_0_level_r <= RESQ_RST_ZERO;
            linear_regulator_1_level_r <= RESQ_RST_ZERO;
            step_down_converter_0_sequence_delays_r <= RESQ_RST_ZERO;
            step_down_converter_1_sequence_delays_r <= RESQ_RST_ZERO;
            linear_regulator_0_sequence_delays_r <= RESQ_RST_ZERO;
            dly_cfg_r <= RESQ_RST_ZERO;
        end else if (REG_WR) begin
            case (REG_ADDR)
                RESQ_OFS_LIN0_CTRL:
                    lin0_control_r <= REG_WDATA & RESQ_MASK_CTRL;
                RESQ_OFS_LIN1_CTRL:
                    linear_regulator_1_control_r <= REG_WDATA & RESQ_MASK_CTRL;
                RESQ_OFS_LIN0_LVL: linear_regulator_0_level_r <= REG_WDATA & RESQ_MASK_LVL;
                RESQ_OFS_LIN1_LVL: linear_regulator_1_level_r <= REG_WDATA & RESQ_MASK_LVL;
                RESQ_OFS_CONV0_DLY: step_down_converter_0_sequence_delays_r <= REG_WDATA;
                RESQ_OFS_CONV1_DLY: step_down_converter_1_sequence_delays_r <= REG_WDATA;
                RESQ_OFS_LIN0_DLY: linear_regulator_0_sequence_delays_r <= REG_WDATA;
                RESQ_OFS_DLY_CFG: dly_cfg_r <= REG_WDATA & RESQ_MASK_CFG;
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Register reads
    // --------------------------------------------------------------
    // Unmapped addresses read zero
    // Busy is reported in bit 2 of the delay configuration byte
    always_comb begin
        case (REG_ADDR)
            RESQ_OFS_LIN0_CTRL: rdata_nxt = lin0_control_r;
            RESQ_OFS_LIN1_CTRL: rdata_nxt = linear_regulator_1_control_r;
            RESQ_OFS_LIN0_LVL: rdata_nxt = linear_regulator_0_level_r;
            RESQ_OFS_LIN1_LVL: rdata_nxt = linear_regulator_1_level_r;
            RESQ_OFS_CONV0_DLY: rdata_nxt = step_down_converter_0_sequence_delays_r;
            RESQ_OFS_CONV1_DLY: rdata_nxt = step_down_converter_1_sequence_delays_r;
            RESQ_OFS_LIN0_DLY: rdata_nxt = linear_regulator_0_sequence_delays_r;
            RESQ_OFS_DLY_CFG: rdata_nxt = {5'h00, |dly_busy, dly_cfg_r[1:0]};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data is registered, so it trails the address by one edge
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= rdata_nxt;
        end
    end

    // --------------------------------------------------------------
    // Pin synchroniser and time base
    // --------------------------------------------------------------
    // Enable pin is asynchronous to REF_CLK, so two flops before use
    // Reset clears both flops to the idle pin level, so no false edge
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= EN_PIN;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Period is a parameter so simulation can use a short step
    // Free-running 0.5 ms tick; first step may be short by up to one tick
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            tick_cnt_r <= 32'h0000_0000;
        end else if (tick) begin
            tick_cnt_r <= 32'h0000_0000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
        end
    end
    // Tick lasts one cycle; the counter clears on it
    assign tick = (tick_cnt_r == 32'(STEP_CYC - 1)); // RL12

    // --------------------------------------------------------------
    // Delay channels: 0 conv0, 1 conv1, 2 lin0
    // --------------------------------------------------------------
    // Channel order fixes which register feeds which output
    // Channel 2 drives only the gated path of linear regulator 0
    assign dly_regs[0] = step_down_converter_0_sequence_delays_r;
    assign dly_regs[1] = step_down_converter_1_sequence_delays_r; // RL10
    assign dly_regs[2] = linear_regulator_0_sequence_delays_r; // RL11

    // All channels share the tick and the synchronised pin, so they
    // see each pin edge on the same cycle
    generate
        for (genvar i = 0; i < RESQ_NCH; i++) begin : g_ch
            resq_bus_if ch_if ();
            assign ch_if.off_wait = dly_regs[i][7:4];
            assign ch_if.on_wait = dly_regs[i][3:0];
            assign ch_if.off_x2 = dly_cfg_r[RESQ_BIT_OFF_X2];
            assign ch_if.on_x2 = dly_cfg_r[RESQ_BIT_ON_X2];
            assign dly_en[i] = ch_if.delayed_en;
            assign dly_busy[i] = ch_if.busy;
            resq_delay_chan u_chan (
                .clk(REF_CLK),
                .rst_n(RST_N),
                .en_pin(pin_sync_r),
                .tick(tick),
                .cfg(ch_if)
            );
        end
    endgenerate

    // --------------------------------------------------------------
    // Regulator enables and discharge
    // --------------------------------------------------------------
    // Linear regulator 1 has no delay register here, so it follows the
    // synchronised pin directly
    assign lin0_on = lin0_control_r[RESQ_BIT_ON] & // RL3
        (!lin0_control_r[RESQ_BIT_GATE] | dly_en[2]); // RL2
    assign lin1_on = linear_regulator_1_control_r[RESQ_BIT_ON] & // RL3
        (!linear_regulator_1_control_r[RESQ_BIT_GATE] | pin_sync_r); // RL2
    // Enables are combinational from flops: a write shows next cycle
    assign LIN0_ENABLE = lin0_on;
    assign LIN1_ENABLE = lin1_on;
    // Converter starts come straight from the channel output flops
    assign CONV0_START = dly_en[0]; // RL6
    assign CONV1_START = dly_en[1]; // RL10
    // Discharge only while off, so it never loads a live output
    assign LIN0_DISCHARGE = !lin0_on & lin0_control_r[RESQ_BIT_DIS]; // RL1
    assign LIN1_DISCHARGE = !lin1_on & linear_regulator_1_control_r[RESQ_BIT_DIS]; // RL1

    // --------------------------------------------------------------
    // Level codes and status
    // --------------------------------------------------------------
    // Code maps to 0.8 V + 100 mV per step; 1A..1F are passed unchecked
    assign LIN0_LEVEL_CODE = linear_regulator_0_level_r[4:0]; // RL4
    assign LIN1_LEVEL_CODE = linear_regulator_1_level_r[4:0]; // RL4
    // Busy covers every channel still counting toward its target
    assign SEQ_BUSY = |dly_busy;
endmodule
`default_nettype wire

// ==== resq_top_monitor.sv ====
// Checker for the sequencer top: watches its ports only.
// Assumes it is bound into resq_top and sees its parameter.
`timescale 1ns/10ps
`default_nettype none
module resq_top_monitor
    import resq_pkg::*;
#(
    parameter int STEP_CYC = RESQ_STEP_CYC
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Register port
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    // Pin and regulator controls
    input wire logic EN_PIN,
    input wire logic LIN0_ENABLE,
    input wire logic LIN1_ENABLE,
    input wire logic CONV0_START,
    input wire logic LIN0_DISCHARGE,
    input wire logic LIN1_DISCHARGE,
    input wire logic [4:0] LIN0_LEVEL_CODE,
    input wire logic [4:0] LIN1_LEVEL_CODE
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // Write strobe at one offset
    sequence s_wr(logic [7:0] a);
        REG_WR && REG_ADDR == a;
    endsequence
    property p_dis0;
        LIN0_ENABLE |-> !LIN0_DISCHARGE;
    endproperty
    a_dis0: assert property (p_dis0)
        else $error("lin0 discharge while on");
    property p_dis1;
        LIN1_ENABLE |-> !LIN1_DISCHARGE;
    endproperty
    a_dis1: assert property (p_dis1)
        else $error("lin1 discharge while on");
    property p_on0;
        s_wr(8'h08) ##0 REG_WDATA[1:0] == 2'b01 |=> LIN0_ENABLE;
    endproperty
    a_on0: assert property (p_on0)
        else $error("lin0 not on after write");
    property p_off0;
        s_wr(8'h08) ##0 REG_WDATA[2:0] == 3'b100
            |=> !LIN0_ENABLE && LIN0_DISCHARGE;
    endproperty
    a_off0: assert property (p_off0)
        else $error("lin0 off or discharge wrong");
    property p_gate1;
        s_wr(8'h09) ##0 REG_WDATA[1:0] == 2'b01 |=> LIN1_ENABLE;
    endproperty
    a_gate1: assert property (p_gate1)
        else $error("lin1 ungated enable lost");
    property p_lvl0;
        s_wr(8'h0A) |=> {3'b000, LIN0_LEVEL_CODE} ==
            ($past(REG_WDATA) & 8'h1F);
    endproperty
    a_lvl0: assert property (p_lvl0)
        else $error("lin0 level code wrong");
    property p_lvl1;
        s_wr(8'h0B) |=> {3'b000, LIN1_LEVEL_CODE} ==
            ($past(REG_WDATA) & 8'h1F);
    endproperty
    a_lvl1: assert property (p_lvl1)
        else $error("lin1 level code wrong");
    // Output may only move after the pin has passed the synchroniser
    property p_rise0;
        $rose(CONV0_START) |-> $past(EN_PIN, 2);
    endproperty
    a_rise0: assert property (p_rise0)
        else $error("converter 0 started without pin");
    property p_fall0;
        $fell(CONV0_START) |-> !$past(EN_PIN, 2);
    endproperty
    a_fall0: assert property (p_fall0)
        else $error("converter 0 stopped with pin high");
endmodule
`default_nettype wire

// ==== resq_host_model.sv ====
// Host model: byte register writes and reads, and the enable pin.
// Assumes registered read data one edge after the address.
`timescale 1ns/10ps
`default_nettype none
module resq_host_model (
    // Clock and read data
    input wire logic clk,
    input wire logic [7:0] rdata,
    // Register port and pin
    output logic wr,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic en_pin
);
    // Idle values before the first edge
    initial begin
        wr = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        en_pin = 1'b0;
    end
    // One-cycle strobe; data is scrambled once the write is taken
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 d = rdata;
    endtask
    task automatic set_pin(input logic v);
        @(posedge clk);
        en_pin <= v;
    endtask
endmodule
`default_nettype wire

// ==== resq_top_tb.sv ====
// Testbench for the sequencer: registers, gating and pin delays.
// Assumes the host model drives every design input except the clock and reset.
`timescale 1ns/10ps
`default_nettype none
module resq_top_tb;
    import resq_pkg::*;
    localparam int STEP = 10;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, en_pin, l0, l1, c0, c1, d0, d1, busy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic [4:0] lv0, lv1;
    int error_cnt = 0;
    int tests_run = 0;
    // ----------------------------------------
    // Clock, design and host
    // ----------------------------------------
    always #5 ref_clk = ~ref_clk;
    resq_top #(.STEP_CYC(STEP)) i_resq_top (.REF_CLK(ref_clk),
        .RST_N(rst_n), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .EN_PIN(en_pin),
        .LIN0_ENABLE(l0), .LIN1_ENABLE(l1), .CONV0_START(c0),
        .CONV1_START(c1), .LIN0_DISCHARGE(d0), .LIN1_DISCHARGE(d1),
        .LIN0_LEVEL_CODE(lv0), .LIN1_LEVEL_CODE(lv1), .SEQ_BUSY(busy));
    resq_host_model i_resq_host_model (.clk(ref_clk), .rdata(reg_rdata),
        .wr(reg_wr), .addr(reg_addr), .wdata(reg_wdata), .en_pin(en_pin));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic st(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? c0 : (s == 1) ? c1 : l0;
    endfunction
    // Register write then pin edge; the edge count must sit in the step
    // window, since the first tick of a count is free running
    task automatic t_delay(input int s, input logic [7:0] a, d, cfg,
                           input logic v, input int n);
        int c;
        i_resq_host_model.wr_reg(a, d);
        i_resq_host_model.wr_reg(8'h13, cfg);
        i_resq_host_model.set_pin(v);
        c = 0;
        while (pick(s) !== v && c < 400) begin
            st(1);
            c++;
        end
        chk(8'(c >= (n - 1) * STEP && c <= n * STEP + 8), 8'h01);
    endtask
    task automatic t_regs();
        logic [7:0] codes [3] = '{8'h00, 8'h19, 8'hE5};
        i_resq_host_model.rd_reg(8'h08, rd);
        chk(rd, 8'h04);
        chk({4'h0, d0, d1, l0, l1}, 8'h0C);
        i_resq_host_model.wr_reg(8'h20, 8'hFF);
        i_resq_host_model.rd_reg(8'h20, rd);
        chk(rd, 8'h00);
        i_resq_host_model.wr_reg(8'h08, 8'h05);
        st(1);
        chk({6'h00, l0, d0}, 8'h02);
        i_resq_host_model.wr_reg(8'h08, 8'h04);
        st(1);
        chk({6'h00, l0, d0}, 8'h01);
        i_resq_host_model.wr_reg(8'h08, 8'h00);
        st(1);
        chk({6'h00, l0, d0}, 8'h00);
        i_resq_host_model.wr_reg(8'h09, 8'h03);
        st(8);
        chk({7'h00, l1}, 8'h00);
        i_resq_host_model.set_pin(1'b1);
        st(8);
        chk({7'h00, l1}, 8'h01);
        i_resq_host_model.wr_reg(8'h09, 8'h05);
        i_resq_host_model.set_pin(1'b0);
        st(8);
        chk({7'h00, l1}, 8'h01);
        foreach (codes[i]) begin
            i_resq_host_model.wr_reg(8'h0A, codes[i]);
            i_resq_host_model.wr_reg(8'h0B, codes[i]);
            i_resq_host_model.rd_reg(8'h0A, rd);
            chk(rd, codes[i] & 8'h1F);
            chk({3'h0, lv0}, codes[i] & 8'h1F);
            chk({3'h0, lv1}, codes[i] & 8'h1F);
        end
    endtask
    // Pin drops mid-count: the pending start must be dropped
    task automatic t_restart();
        int n;
        i_resq_host_model.wr_reg(8'h0C, 8'h0F);
        i_resq_host_model.set_pin(1'b0);
        st(10);
        i_resq_host_model.set_pin(1'b1);
        st(30);
        chk({7'h00, busy}, 8'h01);
        i_resq_host_model.rd_reg(8'h13, rd);
        chk(rd, 8'h04);
        i_resq_host_model.set_pin(1'b0);
        n = 0;
        repeat (200) begin
            st(1);
            n += c0;
        end
        chk(8'(n), 8'h00);
        chk({7'h00, busy}, 8'h00);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_delay(0, 8'h0C, 8'h03, 8'h00, 1'b1, 3);
        t_delay(0, 8'h0C, 8'h50, 8'h02, 1'b0, 10);
        t_delay(1, 8'h0D, 8'h0F, 8'h01, 1'b1, 30);
        t_delay(1, 8'h0D, 8'hF0, 8'h00, 1'b0, 15);
        i_resq_host_model.wr_reg(8'h08, 8'h03);
        t_delay(2, 8'h0E, 8'h02, 8'h00, 1'b1, 2);
        t_delay(2, 8'h0E, 8'h10, 8'h00, 1'b0, 1);
        t_delay(0, 8'h0C, 8'h00, 8'h00, 1'b1, 0);
        t_restart();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
bind resq_top resq_top_monitor #(.STEP_CYC(STEP_CYC)) i_resq_top_monitor (
    .REF_CLK, .RST_N, .REG_WR, .REG_ADDR, .REG_WDATA, .EN_PIN,
    .LIN0_ENABLE, .LIN1_ENABLE, .CONV0_START, .LIN0_DISCHARGE,
    .LIN1_DISCHARGE, .LIN0_LEVEL_CODE, .LIN1_LEVEL_CODE);
`default_nettype wire
